// ===== src/mfd_pkg.sv
// Purpose: Shared types and constants for the SPI mode fault detector.
// Assumes: Control bits are loaded by a one-cycle write strobe from the CPU side.
// Notes: Reset values are named here once and used by the design.
package mfd_pkg;

    typedef struct packed {
        logic select_pin_disable_bit;
        logic master;
        logic enable;
    } mfd_ctrl_t;

    typedef struct packed {
        logic mode_fault;
        logic ss_level;
    } mfd_status_t;

    localparam int MFD_SYNC_STAGES = 2;
    localparam mfd_ctrl_t MFD_CTRL_RST = '{select_pin_disable_bit: 1'b0, master: 1'b0, enable: 1'b0};
    localparam logic MFD_FAULT_RST = 1'b0;
    localparam logic MFD_SS_IDLE = 1'b1;

endpackage : mfd_pkg

// ===== src/mfd_sync.sv
// Purpose: Multi-stage level synchroniser into the clock domain of clk_i.
// Assumes: The input is a slowly changing level, never a single-cycle pulse.
// Notes: Only the last stage is visible; earlier stages feed nothing else.
module mfd_sync
    import mfd_pkg::*;
#(
    parameter int STAGES = MFD_SYNC_STAGES,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);

    logic [STAGES-1:0] stage_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_r <= {STAGES{RST_VAL}};
        end else begin
            stage_r <= {stage_r[STAGES-2:0], d_i};
        end
    end

    assign q_o = stage_r[STAGES-1];

endmodule : mfd_sync

// ===== src/mfd_mode_fault.sv
// Purpose: Mode fault detection for an SPI master, watching the slave select pin.
// Assumes: The select pin is sampled on the link clock; the CPU side runs on clk_sys_i.
// Notes: The link clock must run while the pin is to be watched.

// What this block does
// - As master, a select level contradicting the master role sets the mode fault flag.
// - With select disable cleared and master set, a low select input sets the mode fault flag.
// - A mode fault raises the receiver/error interrupt request to the CPU.
// - A mode fault clears the SPI enable bit, disabling the SPI.
// - A mode fault clears the master select bit, leaving master configuration.
// - Select disable set stops faults from the pin; pin becomes general purpose.
// - Flag clears only by a status read showing it set, then a control write.
// - Clearing the select disable bit leaves a set flag unchanged.
module mfd_mode_fault
    import mfd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_link_i,
    input wire logic ss_n_i,
    input wire logic status_read_i,
    input wire logic ctrl_write_i,
    input wire mfd_ctrl_t ctrl_wdata_i,
    output mfd_ctrl_t ctrl_o,
    output mfd_status_t status_o,
    output logic irq_o,
    output logic ss_gpio_o
);

    mfd_ctrl_t ctrl_r;
    logic mode_fault_r;
    logic read_armed_r;
    logic ss_level_r;
    logic rst_link;
    logic ss_link;
    logic ss_low_link_r;
    logic ss_low_sys;
    logic fault_evt;
    logic clear_evt;

    // Reset reaches the link domain through its own synchroniser
    mfd_sync #(.STAGES(MFD_SYNC_STAGES), .RST_VAL(1'b1)) u_rst_link (
        .clk_i(clk_link_i),
        .rst_i(1'b0),
        .d_i(rst_i),
        .q_o(rst_link)
    );

    mfd_sync #(.STAGES(MFD_SYNC_STAGES), .RST_VAL(MFD_SS_IDLE)) u_ss_pin (
        .clk_i(clk_link_i),
        .rst_i(rst_link),
        .d_i(ss_n_i),
        .q_o(ss_link)
    );

    // Registered low detect on the link side; only this flop crosses over
    always_ff @(posedge clk_link_i) begin
        if (rst_link) begin
            ss_low_link_r <= 1'b0;
        end else begin
            ss_low_link_r <= ~ss_link;
        end
    end

    mfd_sync #(.STAGES(MFD_SYNC_STAGES), .RST_VAL(1'b0)) u_ss_low (
        .clk_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(ss_low_link_r),
        .q_o(ss_low_sys)
    );

    // Level based: a master seeing select low is inconsistent with its role
    assign fault_evt = ctrl_r.master & ~ctrl_r.select_pin_disable_bit & ss_low_sys;
    assign clear_evt = ctrl_write_i & read_armed_r;

    // Fault wins over a same-cycle write so the SPI cannot stay enabled
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_r <= MFD_CTRL_RST;
        end else begin
            if (ctrl_write_i) begin
                ctrl_r <= ctrl_wdata_i;
            end
            if (fault_evt) begin
                ctrl_r.enable <= 1'b0;
                ctrl_r.master <= 1'b0;
                if (ctrl_write_i) begin
                    ctrl_r.select_pin_disable_bit <= ctrl_wdata_i.select_pin_disable_bit;
                end
            end
        end
    end

    // Set beats clear so a fault arriving during the clear is not lost
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_fault_r <= MFD_FAULT_RST;
        end else if (fault_evt) begin
            mode_fault_r <= 1'b1;
        end else if (clear_evt) begin
            mode_fault_r <= 1'b0;
        end
    end

    // Arming needs the read to have returned the flag set
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            read_armed_r <= 1'b0;
        end else if (clear_evt) begin
            read_armed_r <= 1'b0;
        end else if (status_read_i && mode_fault_r) begin
            read_armed_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ss_level_r <= MFD_SS_IDLE;
        end else begin
            ss_level_r <= ~ss_low_sys;
        end
    end

    assign ctrl_o = ctrl_r;
    assign status_o = '{mode_fault: mode_fault_r, ss_level: ss_level_r};
    assign irq_o = mode_fault_r;
    assign ss_gpio_o = ss_level_r;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_read_hit;
        status_read_i && mode_fault_r && !ctrl_write_i;
    endsequence

    sequence seq_quiet_write;
        ctrl_write_i && !fault_evt;
    endsequence

    AST_FAULT_SETS: assert property (fault_evt |=> mode_fault_r)
        else $error("mode fault not flagged after fault condition");

    AST_SS_LOW_SETS: assert property (
        $rose(ss_low_sys) && ctrl_r.master && !ctrl_r.select_pin_disable_bit |=> mode_fault_r)
        else $error("select low as master did not set flag");

    AST_IRQ_RAISED: assert property (fault_evt |=> irq_o [*1] ##0 status_o.mode_fault)
        else $error("interrupt request missing after mode fault");

    AST_ENABLE_CLEARED: assert property (fault_evt |=> !ctrl_o.enable)
        else $error("enable bit not cleared by mode fault");

    AST_MASTER_CLEARED: assert property (fault_evt |=> !ctrl_o.master)
        else $error("master bit not cleared by mode fault");

    AST_SELECT_PIN_DISABLE_BIT_BLOCKS: assert property (
        !mode_fault_r && ctrl_r.select_pin_disable_bit |=> !mode_fault_r)
        else $error("flag set while select disable was on");

    AST_CLEAR_SEQ: assert property (seq_read_hit ##1 seq_quiet_write |=> !mode_fault_r)
        else $error("read then write did not clear mode fault");

    AST_FELL_CAUSE: assert property (
        $fell(mode_fault_r) |-> $past(ctrl_write_i) && $past(read_armed_r))
        else $error("mode fault cleared without the sequence");

    // A read in the same cycle would arm a legal clear one cycle later
    AST_SELECT_PIN_DISABLE_BIT_CLR_KEEPS: assert property (
        mode_fault_r && !read_armed_r && !status_read_i && ctrl_write_i && ctrl_r.select_pin_disable_bit
        && !ctrl_wdata_i.select_pin_disable_bit |=> mode_fault_r [*2])
        else $error("clearing select disable dropped the flag");

    AST_UNARMED_WRITE: assert property (
        mode_fault_r && !read_armed_r && !status_read_i |=> mode_fault_r)
        else $error("flag dropped without a prior status read");

    sequence seq_fault_hit;
        ctrl_r.master && !ctrl_r.select_pin_disable_bit && ss_low_sys;
    endsequence

    AST_PIN_FAULT: assert property (
        seq_fault_hit |=> mode_fault_r && !ctrl_o.master && !ctrl_o.enable)
        else $error("select low as master did not fault fully");

    AST_SLAVE_QUIET: assert property (
        !ctrl_r.master && !mode_fault_r |=> !mode_fault_r)
        else $error("flag set while not configured as master");

    AST_SELECT_PIN_DISABLE_BIT_PIN_IGNORED: assert property (
        ctrl_r.select_pin_disable_bit && ss_low_sys && !mode_fault_r |=> !mode_fault_r)
        else $error("select low raised a fault with select disable on");

    AST_ONE_SHOT: assert property (
        fault_evt |=> !fault_evt)
        else $error("fault condition stayed after master was dropped");

    // The arm must only come from a read that saw the flag set
    AST_READ_ARMS: assert property (
        seq_read_hit |=> read_armed_r)
        else $error("status read with flag set did not arm the clear");

    AST_ARM_CAUSE: assert property (
        $rose(read_armed_r) |-> $past(status_read_i) && $past(mode_fault_r))
        else $error("clear armed without a status read showing the flag");

    AST_ARM_DROPS: assert property (
        clear_evt |=> !read_armed_r)
        else $error("clear arm kept after the clearing write");

    AST_NO_ARM_UNSET: assert property (
        !mode_fault_r && !read_armed_r |=> !read_armed_r)
        else $error("clear armed while the flag was clear");

    // Control bits change only by a write or a fault
    AST_WRITE_LOADS: assert property (
        ctrl_write_i && !fault_evt |=> ctrl_o == $past(ctrl_wdata_i))
        else $error("control write did not load the control bits");

    AST_CTRL_STEADY: assert property (
        !ctrl_write_i && !fault_evt |=> $stable(ctrl_o))
        else $error("control bits changed without write or fault");

    AST_IRQ_HOLDS: assert property (
        irq_o && !clear_evt |=> irq_o)
        else $error("interrupt request dropped before the clear");

endmodule : mfd_mode_fault

// ===== tb/mfd_far_master.sv
// Purpose: Second bus master that may pull the select line of the block low.
// Assumes: The select line has a pull-up, so a released line reads high.
// Notes: Changes only on the link clock, like a real neighbour master.
module mfd_far_master (
    input wire logic clk_link_i,
    input wire logic pull_low_i,
    output logic ss_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drive_r = 1'b0;
    always @(posedge clk_link_i) begin
        drive_r <= pull_low_i;
    end
    // Released line goes to the pull-up level, never holds a stale low
    assign ss_n_o = drive_r ? 1'b0 : 1'b1;
endmodule : mfd_far_master

// ===== tb/mfd_mode_fault_bench.sv
// Purpose: Self-checking bench for the mode fault detector.
// Assumes: Strobes are one-cycle pulses, driven 1 ns after the system edge.
// Notes: Link clock runs freely with an odd phase offset to exercise the crossing.
module mfd_mode_fault_bench
    import mfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic clk_link_i = 1'b0;
    logic rst_i = 1'b1;
    logic ss_n_i;
    logic status_read_i = 1'b0;
    logic ctrl_write_i = 1'b0;
    logic pull_low = 1'b0;
    mfd_ctrl_t ctrl_wdata_i = '0;
    mfd_ctrl_t ctrl_o;
    mfd_status_t status_o;
    logic irq_o;
    logic ss_gpio_o;
    int miscompares = 0;
    int checks_done = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;
    initial begin
        #3.1;
        forever #6 clk_link_i = ~clk_link_i;
    end

    mfd_far_master i_mfd_far_master (.clk_link_i(clk_link_i), .pull_low_i(pull_low),
        .ss_n_o(ss_n_i));
    mfd_mode_fault i_mfd_mode_fault (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .clk_link_i(clk_link_i), .ss_n_i(ss_n_i), .status_read_i(status_read_i),
        .ctrl_write_i(ctrl_write_i), .ctrl_wdata_i(ctrl_wdata_i), .ctrl_o(ctrl_o),
        .status_o(status_o), .irq_o(irq_o), .ss_gpio_o(ss_gpio_o));

    task chk(input logic [2:0] seen, input logic [2:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %b expected %b", $time, seen, exp);
        end
    endtask : chk

    task strobe(input logic is_write, input mfd_ctrl_t d);
        @(posedge clk_sys_i);
        #1;
        ctrl_write_i = is_write;
        status_read_i = !is_write;
        ctrl_wdata_i = d;
        @(posedge clk_sys_i);
        #1;
        ctrl_write_i = 1'b0;
        status_read_i = 1'b0;
    endtask : strobe

    task read_then_write(input mfd_ctrl_t d);
        @(posedge clk_sys_i);
        #1;
        status_read_i = 1'b1;
        chk({2'b00, status_o.mode_fault}, 3'b001);
        @(posedge clk_sys_i);
        #1;
        status_read_i = 1'b0;
        ctrl_write_i = 1'b1;
        ctrl_wdata_i = d;
        @(posedge clk_sys_i);
        #1;
        ctrl_write_i = 1'b0;
    endtask : read_then_write

    task idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : idle

    task s_fault;
        strobe(1'b1, 3'b011);
        chk(ctrl_o, 3'b011);
        pull_low = 1'b1;
        // Look a step after each edge so the flop has settled
        for (int i = 0; i < 40 && irq_o !== 1'b1; i++) idle(1);
        chk({2'b00, status_o.mode_fault}, 3'b001);
        chk({2'b00, irq_o}, 3'b001);
        chk({2'b00, ctrl_o.enable}, 3'b000);
        chk({2'b00, ctrl_o.master}, 3'b000);
        pull_low = 1'b0;
        idle(20);
    endtask : s_fault

    task s_clear;
        strobe(1'b1, 3'b100);
        chk({2'b00, status_o.mode_fault}, 3'b001);
        strobe(1'b1, 3'b000);
        chk({2'b00, status_o.mode_fault}, 3'b001);
        read_then_write(3'b001);
        chk({1'b0, status_o.mode_fault, irq_o}, 3'b000);
        chk(ctrl_o, 3'b001);
        pull_low = 1'b1;
        idle(30);
        chk({2'b00, status_o.mode_fault}, 3'b000);
        pull_low = 1'b0;
        idle(20);
    endtask : s_clear

    task s_gpio;
        strobe(1'b1, 3'b110);
        pull_low = 1'b1;
        idle(30);
        chk({2'b00, status_o.mode_fault}, 3'b000);
        chk(ctrl_o, 3'b110);
        chk({1'b0, status_o.ss_level, ss_gpio_o}, 3'b000);
        pull_low = 1'b0;
        idle(20);
        chk({1'b0, status_o.ss_level, ss_gpio_o}, 3'b011);
    endtask : s_gpio

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        idle(20);
        rst_i = 1'b0;
        chk({ctrl_o.enable, status_o.mode_fault, irq_o}, 3'b000);
        chk({1'b0, status_o.ss_level, ss_gpio_o}, 3'b011);
        s_fault();
        s_clear();
        s_gpio();
        complete_run();
    end

    // Whole run needs about 1 us; the margin covers slow crossings
    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
endmodule : mfd_mode_fault_bench
